// ### inc/bfb_consts.vh
// Constants for the burst flash bus interface
`ifndef BFB_CONSTS_VH
`define BFB_CONSTS_VH
`define BFB_ADDR_W_32M 21
`define BFB_ADDR_W_64M 22
`define BFB_ADDR_W_128M 23
`define BFB_DATA_W 16
`define BFB_RCR_POL_BIT 10
`define BFB_LATENCY 3
`define BFB_BURST_LEN 4
`define BFB_MEM_DEPTH_LOG2 6
`define BFB_MODE_ASYNC 1'b0
`define BFB_MODE_SYNC 1'b1
`endif

// ### rtl/bfb_edge_det.v
// Synchronous edge detector for host strobes sampled on the system clock
`timescale 1ns/10ps
`default_nettype none
module bfb_edge_det #(
  parameter RST_LVL = 1'b1
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_sig,
  output reg o_rise,
  output reg o_fall,
  output reg o_level
);
  reg prev;

  // Previous sample and registered edge pulses
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      // Reset to the pin's idle level so release makes no false edge
      prev <= RST_LVL;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
      o_level <= RST_LVL;
    end
    else
    begin
      prev <= i_sig;
      o_level <= i_sig;
      o_rise <= i_sig & ~prev;
      o_fall <= ~i_sig & prev;
    end
  end
endmodule
`default_nettype wire

// ### rtl/bfb_mem.v
// Small array model with registered read data
`timescale 1ns/10ps
`default_nettype none
module bfb_mem #(
  parameter AW = 6,
  parameter DW = 16
) (
  input wire i_sys_clk,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write port and registered read port
  always @(posedge i_sys_clk)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// ### rtl/bfb_top.v
// Device-side pin interface of a partitioned burst NOR flash
// Functional notes
// - Address width follows density: 21, 22 or 23 bits.
// - 16-bit data bus carries writes in and read data out.
// - Data outputs float when deselected or outputs disabled.
// - Write data is captured into an internal holding latch.
// - Sync address latched on strobe rise or first active clock edge.
// - Active bus clock edge is selectable rising or falling.
// - Bus clock advances internal burst address generator.
// - Chip select enables the internal logic and buffers.
// - Chip select deasserted means standby with data and pending outputs floated.
// - Data driven only while output enable asserted.
// - Reset low clears sequencer and refuses writes.
// - After reset the device is in asynchronous array read.
// - Data-pending output flags valid data in sync reads.
// - Data-pending polarity follows read configuration bit 10.
// - Data-pending floats when chip select is deasserted.
// - Data-pending is not gated by output enable.
// - Write address and data taken on write strobe rising edge.
`include "bfb_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module bfb_top #(
  parameter ADDR_W = `BFB_ADDR_W_128M,
  parameter DATA_W = `BFB_DATA_W,
  parameter MEM_AW = `BFB_MEM_DEPTH_LOG2,
  parameter LATENCY = `BFB_LATENCY,
  parameter BURST_LEN = `BFB_BURST_LEN
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_rst_pin_n,
  input wire [ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_data,
  output reg [DATA_W-1:0] o_data,
  output wire o_data_oe_n,
  input wire i_addr_valid_strobe_n,
  input wire i_chip_sel_n,
  input wire i_out_en_n,
  input wire i_wr_strobe_n,
  input wire i_bus_clk,
  input wire i_clk_edge_fall,
  input wire i_sync_mode,
  input wire [15:0] i_read_cfg,
  output wire o_wait,
  output wire o_wait_oe_n,
  output wire [DATA_W-1:0] o_hold_data,
  output wire o_hold_valid
);
  // Small counter width for latency and burst position
  localparam CW = 4;
  // Encoded read states
  localparam ST_ARRAY = 2'd0;
  localparam ST_LATENCY = 2'd1;
  localparam ST_BURST = 2'd2;

  // Pin edge pulses and qualifiers
  wire adv_rise;
  wire bclk_rise;
  wire bclk_fall;
  wire bclk_lvl;
  wire we_rise;
  wire bclk_edge;
  wire selected;
  wire in_reset;
  wire [DATA_W-1:0] rdata;
  // Sequencer and latch state
  reg [ADDR_W-1:0] wr_addr_q;
  reg [DATA_W-1:0] wr_data_q;
  reg [ADDR_W-1:0] addr_q;
  reg [ADDR_W-1:0] burst_addr;
  reg [DATA_W-1:0] hold_data;
  reg hold_valid;
  reg [1:0] state;
  reg [CW-1:0] cnt;
  reg addr_taken;
  reg data_ready;
  reg [MEM_AW-1:0] raddr;

  // Pin reset and chip select qualify the latch, sequencer, array write and drivers below
  assign in_reset = ~i_rst_pin_n;
  assign selected = ~i_chip_sel_n & ~in_reset;

  // Strobes are sampled as levels; each edge is seen one cycle late,
  // which every timing count below allows for
  bfb_edge_det u_adv (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_sig(i_addr_valid_strobe_n),
    .o_rise(adv_rise),
    .o_fall(),
    .o_level()
  );

  // Bus clock idles low, so its detector resets low to avoid a false fall
  bfb_edge_det #(
    .RST_LVL(1'b0)
  ) u_bclk (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_sig(i_bus_clk),
    .o_rise(bclk_rise),
    .o_fall(bclk_fall),
    .o_level(bclk_lvl)
  );

  // Write strobe rise marks the end of a write cycle
  bfb_edge_det u_we (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_sig(i_wr_strobe_n),
    .o_rise(we_rise),
    .o_fall(),
    .o_level()
  );

  // Selectable active bus clock edge
  assign bclk_edge = i_clk_edge_fall ? bclk_fall : bclk_rise;

  // Address and data as they stood while the strobe was low, so the host
  // may change the bus as soon as the strobe rises
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_addr_q <= {ADDR_W{1'b0}};
      wr_data_q <= {DATA_W{1'b0}};
    end
    else if (!i_wr_strobe_n)
    begin
      wr_addr_q <= i_addr;
      wr_data_q <= i_data;
    end
  end

  // Write capture on write strobe rise; refused under reset or deselect
  // The holding latch keeps the last word until the next accepted write
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hold_data <= {DATA_W{1'b0}};
      hold_valid <= 1'b0;
    end
    else if (in_reset)
      hold_valid <= 1'b0;
    else if (we_rise && selected)
    begin
      hold_data <= wr_data_q;
      hold_valid <= 1'b1;
    end
  end

  assign o_hold_data = hold_data;
  assign o_hold_valid = hold_valid;

  // Read sequencer: async array read, or sync latency then burst
  // Latency counts active bus edges after the address is taken; the burst
  // then runs BURST_LEN edges before the pending flag returns
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= ST_ARRAY;
      cnt <= {CW{1'b0}};
      addr_q <= {ADDR_W{1'b0}};
      burst_addr <= {ADDR_W{1'b0}};
      addr_taken <= 1'b0;
      data_ready <= 1'b0;
    end
    else if (in_reset)
    begin
      state <= ST_ARRAY;
      cnt <= {CW{1'b0}};
      addr_taken <= 1'b0;
      data_ready <= 1'b0;
    end
    else if (!selected)
    begin
      // Deselect ends any burst but keeps the address
      state <= ST_ARRAY;
      addr_taken <= 1'b0;
      data_ready <= 1'b0;
    end
    else
    begin
      if (!i_addr_valid_strobe_n && !(i_sync_mode == `BFB_MODE_SYNC))
        addr_q <= i_addr;
      // Whichever of strobe rise or active edge comes first takes it
      if (i_sync_mode == `BFB_MODE_SYNC && !addr_taken &&
          (adv_rise || (bclk_edge && !i_addr_valid_strobe_n)))
      begin
        addr_q <= i_addr;
        burst_addr <= i_addr;
        addr_taken <= 1'b1;
        state <= ST_LATENCY;
        cnt <= {CW{1'b0}};
        data_ready <= 1'b0;
      end
      else
      begin
        // A new strobe low period during the burst rearms the capture
        if (!i_addr_valid_strobe_n && state == ST_BURST)
          addr_taken <= 1'b0;
        case (state)
          // Async reads need no pending flag
          ST_ARRAY:
          begin
            data_ready <= 1'b0;
          end
          // Count active edges until the first word is valid
          ST_LATENCY:
          begin
            if (bclk_edge)
            begin
              if (cnt == LATENCY[CW-1:0] - 4'h1)
              begin
                state <= ST_BURST;
                cnt <= {CW{1'b0}};
                data_ready <= 1'b1;
              end
              else
                cnt <= cnt + 4'h1;
            end
          end
          // Each active edge moves the burst on by one word
          ST_BURST:
          begin
            if (bclk_edge)
            begin
              burst_addr <= burst_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
              if (cnt == BURST_LEN[CW-1:0] - 4'h1)
              begin
                // Past the burst end the data is not yet valid
                state <= ST_LATENCY;
                cnt <= {CW{1'b0}};
                data_ready <= 1'b0;
              end
              else
                cnt <= cnt + 4'h1;
            end
          end
          // Unused code falls back to array read
          default:
          begin
            state <= ST_ARRAY;
          end
        endcase
      end
    end
  end

  // Array read address follows the burst generator in sync mode
  // Async reads index the array straight from the pins
  always @*
  begin
    if (i_sync_mode == `BFB_MODE_SYNC)
      raddr = burst_addr[MEM_AW-1:0];
    else
      raddr = i_addr[MEM_AW-1:0];
  end

  // Array writes use the same captured word as the holding latch
  bfb_mem #(
    .AW(MEM_AW),
    .DW(DATA_W)
  ) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_we(we_rise & selected),
    .i_waddr(wr_addr_q[MEM_AW-1:0]),
    .i_wdata(wr_data_q),
    .i_raddr(raddr),
    .o_rdata(rdata)
  );

  // Registered read data to the pins
  // One register stage keeps the pins clean at the cost of a cycle
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_data <= {DATA_W{1'b0}};
    else
      o_data <= rdata;
  end

  // Data drivers: low enable means driving
  // A low write strobe wins so the device never fights the host
  assign o_data_oe_n = ~(selected & ~i_out_en_n & i_wr_strobe_n);

  // Pending flag is independent of output enable; polarity from bit 10
  // Outside sync mode the flag rests at its not-pending level
  assign o_wait = (i_sync_mode == `BFB_MODE_SYNC && !data_ready) ^
                  ~i_read_cfg[`BFB_RCR_POL_BIT];
  assign o_wait_oe_n = ~selected;

  // Bus clock level is unused beyond the edge pulses
  wire unused_ok = bclk_lvl & addr_q[0];
endmodule
`default_nettype wire

// ### tb/bfb_host.sv
// Host controller model driving the flash pins
`timescale 1ns/10ps
`default_nettype none
module bfb_host (
  input wire logic i_clk,
  output logic [22:0] o_addr,
  output logic [15:0] o_d,
  output logic o_adv_n,
  output logic o_cs_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_bclk,
  output logic o_rpin_n
);
  // Idle bus; bus clock stands still between bursts
  initial
  begin
    {o_addr, o_d, o_bclk} = '0;
    {o_adv_n, o_cs_n, o_oe_n, o_we_n, o_rpin_n} = 5'h1f;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask
  // Address and data held past the strobe rise, then data dropped
  task automatic wr(input logic [22:0] a, input logic [15:0] v);
    o_addr = a;
    o_d = v;
    o_we_n = 1'b0;
    tick(2);
    o_we_n = 1'b1;
    tick(1);
    o_d = ~v;
  endtask
  task automatic adv();
    o_adv_n = 1'b0;
    tick(2);
    o_adv_n = 1'b1;
  endtask
  // One rising and one falling bus edge per loop
  task automatic clocks(input int n);
    repeat (n)
    begin
      o_bclk = 1'b1;
      tick(2);
      o_bclk = 1'b0;
      tick(2);
    end
  endtask
endmodule
`default_nettype wire

// ### tb/bfb_top_chk.sv
// Concurrent checks on the flash pin interface
`timescale 1ns/10ps
`default_nettype none
module bfb_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_rst_pin_n,
  input wire logic i_chip_sel_n,
  input wire logic i_out_en_n,
  input wire logic i_wr_strobe_n,
  input wire logic o_data_oe_n,
  input wire logic o_wait_oe_n,
  input wire logic o_hold_valid,
  input wire logic [15:0] o_hold_data
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Bus drivers follow the select and enable pins
  a_cs_float: assert property (i_chip_sel_n [*3] |-> o_data_oe_n)
    else $error("data driven while deselected");
  a_oe_float: assert property (i_out_en_n [*3] |-> o_data_oe_n)
    else $error("data driven while disabled");
  a_data_drive: assert property ((!i_chip_sel_n && !i_out_en_n && i_rst_pin_n &&
    i_wr_strobe_n) [*3] |-> !o_data_oe_n)
    else $error("data not driven");
  a_wait_float: assert property (i_chip_sel_n [*3] |-> o_wait_oe_n)
    else $error("pending driven while deselected");
  a_wait_drive: assert property ((!i_chip_sel_n && i_rst_pin_n) [*3] |-> !o_wait_oe_n)
    else $error("pending not driven");
  // Writes land only when selected and out of pin reset
  a_pin_rst_clear: assert property (!i_rst_pin_n [*3] |-> !o_hold_valid)
    else $error("latch valid in pin reset");
  a_wr_refused: assert property (i_chip_sel_n [*4] |-> $stable(o_hold_data))
    else $error("latch changed while deselected");
  a_wr_taken: assert property (($rose(i_wr_strobe_n) && !i_chip_sel_n && i_rst_pin_n)
    |-> ##[1:3] o_hold_valid)
    else $error("write not latched");
  c_write: cover property ($rose(o_hold_valid));
  c_read: cover property (!o_data_oe_n);
  c_deselect: cover property ($rose(o_wait_oe_n));
endmodule
bind bfb_top bfb_chk u_chk (.i_sys_clk, .i_rst, .i_rst_pin_n, .i_chip_sel_n, .i_out_en_n,
  .i_wr_strobe_n, .o_data_oe_n, .o_wait_oe_n, .o_hold_valid, .o_hold_data);
`default_nettype wire

// ### tb/bfb_top_tb.sv
// Self-checking bench for the flash pin interface
`timescale 1ns/10ps
`default_nettype none
module bfb_top_tb;
  logic clk = 0;
  logic rst = 1;
  logic cfe = 0;
  logic sync = 0;
  logic [15:0] cfg = '0;
  logic [22:0] addr;
  logic [15:0] d, q, hd;
  logic adv_n, cs_n, oe_n, we_n, bclk, rpin_n, doe_n, wt, woe_n, hv;
  int err_total = 0;
  int n_checks = 0;
  initial forever #12.5 clk = ~clk;
  bfb_host u_host (.i_clk(clk), .o_addr(addr), .o_d(d), .o_adv_n(adv_n), .o_cs_n(cs_n),
    .o_oe_n(oe_n), .o_we_n(we_n), .o_bclk(bclk), .o_rpin_n(rpin_n));
  bfb_top u_dut (.i_sys_clk(clk), .i_rst(rst), .i_rst_pin_n(rpin_n), .i_addr(addr),
    .i_data(d), .o_data(q), .o_data_oe_n(doe_n), .i_addr_valid_strobe_n(adv_n),
    .i_chip_sel_n(cs_n), .i_out_en_n(oe_n), .i_wr_strobe_n(we_n), .i_bus_clk(bclk),
    .i_clk_edge_fall(cfe), .i_sync_mode(sync), .i_read_cfg(cfg), .o_wait(wt),
    .o_wait_oe_n(woe_n), .o_hold_data(hd), .o_hold_valid(hv));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Back-to-back writes; bus released before the latch is read
  task automatic t_write();
    u_host.o_cs_n = 1'b0;
    u_host.wr(23'h0, 16'ha55a);
    u_host.tick(3);
    chk(hd, 16'ha55a);
    chk({15'h0, hv}, 16'h1);
    u_host.wr(23'h7fffff, 16'h0ff0);
    u_host.tick(3);
    chk(hd, 16'h0ff0);
  endtask
  task automatic t_outputs();
    u_host.o_oe_n = 1'b0;
    u_host.tick(3);
    chk({14'h0, doe_n, woe_n}, 16'h0);
    chk(q, 16'h0ff0);
    u_host.o_addr = 23'h0;
    u_host.tick(3);
    chk(q, 16'ha55a);
    u_host.o_oe_n = 1'b1;
    u_host.tick(3);
    chk({14'h0, doe_n, woe_n}, 16'h2);
    u_host.o_cs_n = 1'b1;
    u_host.tick(3);
    chk({14'h0, doe_n, woe_n}, 16'h3);
  endtask
  // Deselected write, then a write inside pin reset
  task automatic t_refuse();
    u_host.wr(23'h6, 16'h1234);
    u_host.tick(3);
    chk(hd, 16'h0ff0);
    u_host.o_cs_n = 1'b0;
    u_host.o_rpin_n = 1'b0;
    u_host.wr(23'h9, 16'h4321);
    u_host.tick(3);
    chk({15'h0, hv}, 16'h0);
    u_host.o_rpin_n = 1'b1;
    u_host.o_oe_n = 1'b0;
    u_host.tick(3);
    chk({15'h0, doe_n}, 16'h0);
    u_host.o_oe_n = 1'b1;
  endtask
  // Pending level for each polarity and bus edge choice
  task automatic t_burst(input logic pol, input logic fe);
    // Other bits toggle so only bit 10 may steer the polarity
    cfg = pol ? 16'h0400 : 16'hfbff;
    cfe = fe;
    sync = 1'b1;
    u_host.o_addr = 23'h7fffff;
    u_host.adv();
    u_host.tick(1);
    chk({15'h0, wt}, {15'h0, pol});
    u_host.clocks(2);
    chk({15'h0, wt}, {15'h0, pol});
    // Third active edge; a falling one is seen two cycles later
    u_host.clocks(1);
    u_host.tick(2);
    chk({15'h0, wt}, {15'h0, ~pol});
    chk({15'h0, woe_n}, 16'h0);
    chk(q, 16'h0ff0);
    // One more active edge wraps the burst address to word 0
    u_host.clocks(1);
    u_host.tick(3);
    chk(q, 16'ha55a);
    // Deselect ends the burst before the next case
    sync = 1'b0;
    u_host.o_cs_n = 1'b1;
    u_host.tick(4);
    chk({15'h0, woe_n}, 16'h1);
    u_host.o_cs_n = 1'b0;
    u_host.tick(2);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    u_host.tick(2);
    t_write();
    t_outputs();
    t_refuse();
    for (int p = 0; p < 2; p++)
      for (int f = 0; f < 2; f++)
        t_burst(p[0], f[0]);
    print_verdict();
  end
  // Run should end within a few hundred cycles
  initial
  begin
    #50000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
